// file: logic/csa_pkg.sv
// Package of constants and carrier types for the configuration store access sequencer.
//
// Behaviour
// - Device generates check bits and corrects read-back words automatically.
// - Manual check code is ignored for writes while write correction is enabled.
// - Access-mode field 01 enters, 10 leaves access mode; other values do nothing.
// - Commands run only while the completion flag reads one.
// - Status bit 4 reads one only while in access mode.
// - Status bit 3 is sticky once any illegal store access occurred.
// - Status bit 0 reads zero while busy, one once the operation completed.
// - Host writes 04h to enter; device reports 1101 1XXXb in operating mode.
// - After a read, upper byte shows in 59h and lower byte in 5Ah.
// - Stored configuration is valid only when word 0 bits 1:0 hold 10b.
// - Limp-home register bit 3 reads one while limp-home mode is active.
// - All converter outputs stay disabled while in access mode.
package csa_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_STORE_ADDRESS = 7'h36;
  localparam logic [6:0] ADDR_WDATA_HIGH    = 7'h37;
  localparam logic [6:0] ADDR_WDATA_LOW     = 7'h38;
  localparam logic [6:0] ADDR_CHECK_CODE    = 7'h39;
  localparam logic [6:0] ADDR_STORE_CONTROL = 7'h3A;
  localparam logic [6:0] ADDR_LIMP_HOME     = 7'h54;
  localparam logic [6:0] ADDR_STORE_STATUS  = 7'h55;
  localparam logic [6:0] ADDR_OP_MODE       = 7'h56;
  localparam logic [6:0] ADDR_RDATA_HIGH    = 7'h59;
  localparam logic [6:0] ADDR_RDATA_LOW     = 7'h5A;

  // ------------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------------
  localparam int         WR_CORR_DIS_BIT   = 7;
  localparam int         RD_CORR_DIS_BIT   = 6;
  localparam int         ACCESS_OK_BIT     = 4;
  localparam int         BAD_ACCESS_BIT    = 3;
  localparam int         DONE_BIT          = 0;
  localparam int         LIMP_HOME_BIT     = 3;
  localparam logic [1:0] MODE_ENTER        = 2'h1;
  localparam logic [1:0] MODE_EXIT         = 2'h2;
  localparam logic [1:0] CMD_IDLE          = 2'h0;
  localparam logic [1:0] CMD_READ          = 2'h1;
  localparam logic [1:0] CMD_WRITE         = 2'h2;
  localparam logic [4:0] OP_MODE_ACCESS    = 5'h1B;
  localparam logic [1:0] VALID_PATTERN     = 2'h2;
  localparam logic [4:0] VALID_WORD_ADDR   = 5'h00;
  localparam int         STORE_WORDS       = 32;

  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [3:0] RESET_CONTROL     = 4'h0;
  // Busy time of one store operation, in clock cycles at 40 MHz.
  localparam logic [4:0] READ_CYCLES       = 5'h04;
  localparam logic [4:0] WRITE_CYCLES      = 5'h10;

  typedef struct packed {
    logic [6:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } csa_req_s;

  typedef struct packed {
    logic [5:0]  check;
    logic [15:0] data;
  } csa_word_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } csa_state_e;

endpackage

// file: logic/csa_top.sv
// Register front end, correction logic and sequencer of the configuration store.
`timescale 1ns/10ps
module csa_top (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire csa_pkg::csa_req_s REQ,
  input  wire logic [2:0]        OP_MODE_LOW,
  input  wire logic [7:0]        OP_MODE_IN,
  input  wire logic              LIMP_HOME_ACTIVE,
  output logic [7:0]             REG_RDATA,
  output logic                   CONV_DISABLE,
  output logic                   STORE_VALID
);

  // ------------------------------------------------------------------
  // Check code helpers
  // ------------------------------------------------------------------
  // Data bit k sits at the k-th non power-of-two position of a 21-bit
  // Hamming word; bit 5 is overall parity so double errors are not miscorrected.
  function automatic logic [4:0] ecc_pos(input int k);
    int         n;
    int         p;
    logic [4:0] r;
    n = 0;
    r = 5'h00;
    for (p = 1; p < 22; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (n == k)
          r = p[4:0];
        n++;
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] ecc_gen(input logic [15:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int k = 0; k < 16; k++)
    begin
      if (d[k])
        c[4:0] = c[4:0] ^ ecc_pos(k);
    end
    c[5] = (^d) ^ (^c[4:0]);
    return c;
  endfunction

  // Single errors are flipped back. A double error leaves the word as read, since
  // guessing a position would only add a third wrong bit.
  function automatic logic [15:0] ecc_fix(input csa_pkg::csa_word_s w);
    logic [4:0]  syn;
    logic [15:0] d;
    logic [5:0]  g;
    g   = ecc_gen(w.data);
    syn = g[4:0] ^ w.check[4:0];
    d   = w.data;
    if (syn != 5'h00 && (^{w.data, w.check}))
    begin
      for (int k = 0; k < 16; k++)
      begin
        if (ecc_pos(k) == syn)
          d[k] = ~d[k];
      end
    end
    return d;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0]          addr_q,   addr_d;
  logic [7:0]          wdh_q,    wdh_d;
  logic [7:0]          wdl_q,    wdl_d;
  logic [7:0]          chk_q,    chk_d;
  logic [3:0]          ctrl_q,   ctrl_d;
  logic                access_q, access_d;
  logic                bad_q,    bad_d;
  logic                done_q,   done_d;
  logic [15:0]         rdat_q,   rdat_d;
  logic [7:0]          rdout_q,  rdout_d;
  logic                valid_q,  valid_d;
  logic [4:0]          cnt_q,    cnt_d;
  logic [4:0]          opa_q,    opa_d;
  csa_pkg::csa_state_e state_q,  state_d;
  csa_pkg::csa_word_s  store_mem [csa_pkg::STORE_WORDS];
  csa_pkg::csa_word_s  wr_word;
  logic                mem_we;
  logic                ctrl_wr;
  logic [1:0]          new_mode;
  logic [1:0]          new_cmd;
  logic                cmd_rd;
  logic                cmd_wr;

  // The command edge is judged against the stored field, not the previous bus write, so
  // a host that skips the return to 00 between two commands gets no second operation.
  assign ctrl_wr  = REQ.wr && (REQ.addr == csa_pkg::ADDR_STORE_CONTROL);
  assign new_mode = REQ.wdata[3:2];
  assign new_cmd  = REQ.wdata[1:0];
  assign cmd_rd   = ctrl_wr && ctrl_q[1:0] == csa_pkg::CMD_IDLE && new_cmd == csa_pkg::CMD_READ;
  assign cmd_wr   = ctrl_wr && ctrl_q[1:0] == csa_pkg::CMD_IDLE && new_cmd == csa_pkg::CMD_WRITE;

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  // Every register write is taken in the cycle of its strobe. Writes to read-only
  // offsets fall through to the default arm and change nothing.
  always_comb
  begin
    addr_d   = addr_q;
    wdh_d    = wdh_q;
    wdl_d    = wdl_q;
    chk_d    = chk_q;
    ctrl_d   = ctrl_q;
    access_d = access_q;
    bad_d    = bad_q;
    rdout_d  = rdout_q;
    if (REQ.wr)
    begin
      unique case (REQ.addr)
        csa_pkg::ADDR_STORE_ADDRESS: addr_d = REQ.wdata;
        csa_pkg::ADDR_WDATA_HIGH:    wdh_d  = REQ.wdata;
        csa_pkg::ADDR_WDATA_LOW:     wdl_d  = REQ.wdata;
        csa_pkg::ADDR_CHECK_CODE:    chk_d  = REQ.wdata;
        csa_pkg::ADDR_STORE_CONTROL: ctrl_d = REQ.wdata[3:0];
        default:                     ;
      endcase
    end
    if (ctrl_wr && new_mode == csa_pkg::MODE_ENTER)
      access_d = 1'b1;
    else if (ctrl_wr && new_mode == csa_pkg::MODE_EXIT)
      access_d = 1'b0;
    // The flag is only ever set here. There is no software clear, so one stray
    // command stays visible until the enable pin resets the device.
    // sticky bad access
    if ((cmd_rd || cmd_wr) && (!access_q || !done_q))
      bad_d = 1'b1;
    // Read data is registered so that REG_RDATA comes from a flip-flop. The cost is
    // one cycle of latency, and a read in the same cycle as a write sees the old value.
    if (REQ.rd)
    begin
      unique case (REQ.addr)
        csa_pkg::ADDR_STORE_ADDRESS: rdout_d = addr_q;
        csa_pkg::ADDR_WDATA_HIGH:    rdout_d = wdh_q;
        csa_pkg::ADDR_WDATA_LOW:     rdout_d = wdl_q;
        csa_pkg::ADDR_CHECK_CODE:    rdout_d = chk_q;
        csa_pkg::ADDR_STORE_CONTROL: rdout_d = {4'h0, ctrl_q};
        csa_pkg::ADDR_LIMP_HOME:
          rdout_d = 8'(LIMP_HOME_ACTIVE) << csa_pkg::LIMP_HOME_BIT;
        csa_pkg::ADDR_STORE_STATUS:
          rdout_d = (8'(access_q) << csa_pkg::ACCESS_OK_BIT)
                  | (8'(bad_q) << csa_pkg::BAD_ACCESS_BIT)
                  | (8'(done_q) << csa_pkg::DONE_BIT);
        csa_pkg::ADDR_OP_MODE:
          rdout_d = access_q ? {csa_pkg::OP_MODE_ACCESS, OP_MODE_LOW} : OP_MODE_IN;
        csa_pkg::ADDR_RDATA_HIGH:    rdout_d = rdat_q[15:8];
        csa_pkg::ADDR_RDATA_LOW:     rdout_d = rdat_q[7:0];
        default:                     rdout_d = csa_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      addr_q   <= csa_pkg::RESET_BYTE;
      wdh_q    <= csa_pkg::RESET_BYTE;
      wdl_q    <= csa_pkg::RESET_BYTE;
      chk_q    <= csa_pkg::RESET_BYTE;
      ctrl_q   <= csa_pkg::RESET_CONTROL;
      access_q <= 1'b0;
      bad_q    <= 1'b0;
      rdout_q  <= csa_pkg::RESET_BYTE;
    end
    else
    begin
      addr_q   <= addr_d;
      wdh_q    <= wdh_d;
      wdl_q    <= wdl_d;
      chk_q    <= chk_d;
      ctrl_q   <= ctrl_d;
      access_q <= access_d;
      bad_q    <= bad_d;
      rdout_q  <= rdout_d;
    end
  end

  // ------------------------------------------------------------------
  // Operation sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    opa_d   = opa_q;
    done_d  = done_q;
    rdat_d  = rdat_q;
    mem_we  = 1'b0;
    wr_word.data = {wdh_q, wdl_q};
    // manual code only when write correction is disabled
    wr_word.check = chk_q[csa_pkg::WR_CORR_DIS_BIT] ? chk_q[5:0] : ecc_gen({wdh_q, wdl_q});
    unique case (state_q)
      csa_pkg::ST_IDLE:
      begin
        if (access_q && done_q && (cmd_rd || cmd_wr))
        begin
          state_d = cmd_rd ? csa_pkg::ST_READ : csa_pkg::ST_WRITE;
          cnt_d   = cmd_rd ? csa_pkg::READ_CYCLES : csa_pkg::WRITE_CYCLES;
          // Latch the word address so a late address write cannot redirect the operation.
          opa_d   = addr_q[4:0];
          done_d  = 1'b0;
        end
      end
      csa_pkg::ST_READ:
      begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01)
        begin
          // The word is corrected once, at completion, so both read registers always
          // show halves of the same fetched word.
          // automatic correction on read-back
          rdat_d  = chk_q[csa_pkg::RD_CORR_DIS_BIT] ? store_mem[opa_q].data
                                                    : ecc_fix(store_mem[opa_q]);
          done_d  = 1'b1;
          state_d = csa_pkg::ST_IDLE;
        end
      end
      csa_pkg::ST_WRITE:
      begin
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01)
        begin
          // Data registers are used as they stand now. The host must not reload them
          // while the completion flag reads zero.
          mem_we  = 1'b1;
          done_d  = 1'b1;
          state_d = csa_pkg::ST_IDLE;
        end
      end
      // The unused state code leads back to idle with the flag set, so a
      // disturbed state register cannot lock the host out for good.
      default:
      begin
        state_d = csa_pkg::ST_IDLE;
        done_d  = 1'b1;
      end
    endcase
    // Validity follows word zero one cycle late. A never-written word zero reads unknown
    // in simulation, which is what an unprogrammed store should look like.
    // validity pattern of word zero
    valid_d = store_mem[csa_pkg::VALID_WORD_ADDR].data[1:0] == csa_pkg::VALID_PATTERN;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= csa_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      opa_q   <= 5'h00;
      done_q  <= 1'b1;
      rdat_q  <= 16'h0000;
      valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      opa_q   <= opa_d;
      done_q  <= done_d;
      rdat_q  <= rdat_d;
      valid_q <= valid_d;
    end
  end

  // The store keeps its content through reset, as non-volatile cells do.
  always_ff @(posedge CLK)
  begin
    if (mem_we)
      store_mem[opa_q] <= wr_word;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // All outputs are plain copies of registers, so nothing combinational reaches a pin.
  assign REG_RDATA    = rdout_q;
  assign CONV_DISABLE = access_q;
  assign STORE_VALID  = valid_q;

endmodule

// file: test/csa_monitor.sv
// Port checker of the configuration store access sequencer.
`timescale 1ns/10ps
module csa_monitor (
  input wire logic              CLK,
  input wire logic              RST,
  input wire csa_pkg::csa_req_s REQ,
  input wire logic [2:0]        OP_MODE_LOW,
  input wire logic [7:0]        OP_MODE_IN,
  input wire logic              LIMP_HOME_ACTIVE,
  input wire logic [7:0]        REG_RDATA,
  input wire logic              CONV_DISABLE,
  input wire logic              STORE_VALID
);
  // --------------------
  // Shadow of the sequencer
  // --------------------
  logic [1:0] cmd_q;
  logic [4:0] cnt_q;
  logic       bad_q;
  logic       ctl_w;
  logic       start_m;
  logic       done_m;
  logic       rd_st;
  assign ctl_w = REQ.wr && REQ.addr == csa_pkg::ADDR_STORE_CONTROL;
  assign start_m = ctl_w && cmd_q == 2'h0 && REQ.wdata[1] != REQ.wdata[0];
  assign done_m = cnt_q == 5'h00;
  assign rd_st = REQ.rd && REQ.addr == csa_pkg::ADDR_STORE_STATUS;
  // The busy count runs on after an exit, since the store operation finishes anyway.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cmd_q <= 2'h0;
      cnt_q <= 5'h00;
      bad_q <= 1'h0;
    end
    else
    begin
      if (ctl_w)
        cmd_q <= REQ.wdata[1:0];
      if (start_m && CONV_DISABLE && done_m)
        cnt_q <= REQ.wdata[0] ? csa_pkg::READ_CYCLES : csa_pkg::WRITE_CYCLES;
      else if (!done_m)
        cnt_q <= cnt_q - 5'h01;
      if (start_m && !(CONV_DISABLE && done_m))
        bad_q <= 1'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  mode_enter_a:
    assert property (ctl_w && REQ.wdata[3:2] == 2'h1 |=> CONV_DISABLE) else $error("no entry");
  mode_exit_a:
    assert property (ctl_w && REQ.wdata[3:2] == 2'h2 |=> !CONV_DISABLE) else $error("no exit");
  mode_noop_a:
    assert property (ctl_w && REQ.wdata[3] == REQ.wdata[2] |=> $stable(CONV_DISABLE))
      else $error("mode changed");
  access_bit_a:
    assert property (rd_st |=> REG_RDATA[4] == $past(CONV_DISABLE)) else $error("access bit");
  bad_bit_a:
    assert property (rd_st |=> REG_RDATA[3] == $past(bad_q)) else $error("bad access bit");
  done_bit_a:
    assert property (rd_st |=> REG_RDATA[0] == $past(done_m)) else $error("done bit");
  op_mode_a:
    assert property (REQ.rd && REQ.addr == csa_pkg::ADDR_OP_MODE |=> REG_RDATA ==
      ($past(CONV_DISABLE) ? {csa_pkg::OP_MODE_ACCESS, $past(OP_MODE_LOW)} : $past(OP_MODE_IN)))
      else $error("operating mode");
  limp_bit_a:
    assert property (REQ.rd && REQ.addr == csa_pkg::ADDR_LIMP_HOME |=>
      REG_RDATA[3] == $past(LIMP_HOME_ACTIVE)) else $error("limp-home bit");
  valid_change_a:
    assert property ($changed(STORE_VALID) |-> $past(RST, 2) || $past(cnt_q, 2) == 5'h01)
      else $error("validity changed");
endmodule
bind csa_top csa_monitor i_csa_monitor (.CLK(CLK), .RST(RST), .REQ(REQ),
  .OP_MODE_LOW(OP_MODE_LOW), .OP_MODE_IN(OP_MODE_IN), .LIMP_HOME_ACTIVE(LIMP_HOME_ACTIVE),
  .REG_RDATA(REG_RDATA), .CONV_DISABLE(CONV_DISABLE), .STORE_VALID(STORE_VALID));

// file: test/csa_host.sv
// Host model that runs the store access sequences over the register strobes.
`timescale 1ns/10ps
module csa_host (
  input  wire logic         CLK,
  input  wire logic [7:0]   REG_RDATA,
  output csa_pkg::csa_req_s REQ
);
  localparam logic [6:0] CTL = csa_pkg::ADDR_STORE_CONTROL;
  // --------------------
  // Bus cycles
  // --------------------
  initial REQ = '0;
  // A released bus shows inverted values, so stale data never looks valid.
  // Each cycle lets one edge pass first, so a release and the next request never
  // fall in the same time step.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    #1 REQ = '{a, 1'h1, 1'h0, d};
    @(posedge CLK);
    #1 REQ = '{~a, 1'h0, 1'h0, ~d};
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge CLK);
    #1 REQ = '{a, 1'h0, 1'h1, ~REQ.wdata};
    @(posedge CLK);
    #1 REQ = '{~a, 1'h0, 1'h0, ~REQ.wdata};
    d = REG_RDATA;
  endtask
  // --------------------
  // Store sequences
  // --------------------
  // poll for done
  task automatic wait_done(output logic ok);
    logic [7:0] s;
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      rd(csa_pkg::ADDR_STORE_STATUS, s);
      ok = s[csa_pkg::DONE_BIT] === 1'h1;
    end
  endtask
  task automatic enter(output logic ok);
    logic [7:0] m;
    logic [7:0] l;
    rd(csa_pkg::ADDR_OP_MODE, m);
    rd(csa_pkg::ADDR_LIMP_HOME, l);
    ok = m[7:3] === 5'h04 && l[3] === 1'h0;
    wr(CTL, 8'h04);
  endtask
  task automatic store_write(input logic [4:0] a, input logic [15:0] d, input logic [5:0] c,
                             output logic ok);
    wr(csa_pkg::ADDR_STORE_ADDRESS, {3'h0, a});
    wr(csa_pkg::ADDR_WDATA_HIGH, d[15:8]);
    wr(csa_pkg::ADDR_WDATA_LOW, d[7:0]);
    wr(csa_pkg::ADDR_CHECK_CODE, {2'h0, c});
    wait_done(ok);
    if (!ok)
      return;
    wr(CTL, 8'h04);
    wr(CTL, 8'h06);
    wait_done(ok);
  endtask
  task automatic store_read(input logic [4:0] a, output logic [15:0] d, output logic ok);
    wr(csa_pkg::ADDR_STORE_ADDRESS, {3'h0, a});
    wait_done(ok);
    if (!ok)
      return;
    wr(CTL, 8'h04);
    wr(CTL, 8'h05);
    wait_done(ok);
    rd(csa_pkg::ADDR_RDATA_HIGH, d[15:8]);
    rd(csa_pkg::ADDR_RDATA_LOW, d[7:0]);
  endtask
endmodule

// file: test/csa_top_bench.sv
// Self-checking bench of the configuration store access sequencer.
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp); end end
module csa_top_bench;
  typedef struct packed {logic [4:0] a; logic [15:0] d; logic [5:0] c; logic v;} csa_row_s;
  localparam logic [6:0] CTL = csa_pkg::ADDR_STORE_CONTROL;
  localparam logic [6:0] STS = csa_pkg::ADDR_STORE_STATUS;
  logic              CLK;
  logic              RST;
  csa_pkg::csa_req_s req;
  logic [7:0]        op_in;
  logic [2:0]        op_low;
  logic              limp;
  logic [7:0]        rdata;
  logic              conv;
  logic              valid;
  logic              ok;
  logic [15:0]       w;
  logic [7:0]        b;
  int                n_mismatch;
  int                check_count;
  // Word 0 bits 1:0 decide validity; the manual code must be ignored.
  csa_row_s rows [4] = '{'{5'h00, 16'h00A6, 6'h00, 1'h1}, '{5'h1F, 16'hFFFF, 6'h3F, 1'h1},
                         '{5'h01, 16'h1234, 6'h15, 1'h1}, '{5'h00, 16'h5501, 6'h00, 1'h0}};
  csa_top i_csa_top (.CLK(CLK), .RST(RST), .REQ(req), .OP_MODE_LOW(op_low), .OP_MODE_IN(op_in),
    .LIMP_HOME_ACTIVE(limp), .REG_RDATA(rdata), .CONV_DISABLE(conv), .STORE_VALID(valid));
  csa_host i_csa_host (.CLK(CLK), .REG_RDATA(rdata), .REQ(req));
  initial
  begin
    CLK = 1'h0;
    forever #12.5 CLK = ~CLK;
  end
  // --------------------
  // Helpers
  // --------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic need(input logic o);
    `CHK(o, 1'h1)
    if (o !== 1'h1)
      finish_test();
  endtask
  task automatic reset_dut;
    RST = 1'h1;
    repeat (12) @(posedge CLK);
    #1 RST = 1'h0;
  endtask
  // --------------------
  // Sequence
  // --------------------
  initial
  begin
    op_in = 8'h20;
    op_low = 3'h5;
    limp = 1'h0;
    reset_dut();
    i_csa_host.rd(STS, b);
    `CHK(b, 8'h01)
    i_csa_host.wr(CTL, 8'h01);
    i_csa_host.rd(STS, b);
    `CHK(b, 8'h09)
    i_csa_host.wr(CTL, 8'h0C);
    i_csa_host.rd(STS, b);
    `CHK(b, 8'h09)
    $display("test refusal done");
    reset_dut();
    i_csa_host.rd(STS, b);
    `CHK(b, 8'h01)
    i_csa_host.enter(ok);
    need(ok);
    `CHK(conv, 1'h1)
    i_csa_host.rd(csa_pkg::ADDR_OP_MODE, b);
    `CHK(b, {csa_pkg::OP_MODE_ACCESS, 3'h5})
    for (int i = 0; i < 4; i++)
    begin
      i_csa_host.store_write(rows[i].a, rows[i].d, rows[i].c, ok);
      need(ok);
      i_csa_host.store_read(rows[i].a, w, ok);
      need(ok);
      `CHK(w, rows[i].d)
      `CHK(valid, rows[i].v)
    end
    $display("test table done");
    // bump the write counter kept in word 1
    i_csa_host.store_read(5'h01, w, ok);
    need(ok);
    i_csa_host.store_write(5'h01, w + 16'h0001, 6'h00, ok);
    need(ok);
    i_csa_host.store_read(5'h01, w, ok);
    need(ok);
    `CHK(w, 16'h1235)
    i_csa_host.wr(CTL, 8'h04);
    i_csa_host.wr(CTL, 8'h06);
    i_csa_host.wr(CTL, 8'h04);
    i_csa_host.wr(CTL, 8'h05);
    i_csa_host.rd(STS, b);
    `CHK(b, 8'h18)
    i_csa_host.store_read(5'h00, w, ok);
    need(ok);
    `CHK(w, 16'h5501)
    op_low = 3'h2;
    i_csa_host.rd(csa_pkg::ADDR_OP_MODE, b);
    `CHK(b, {csa_pkg::OP_MODE_ACCESS, 3'h2})
    limp = 1'h1;
    i_csa_host.rd(csa_pkg::ADDR_LIMP_HOME, b);
    `CHK(b[3], 1'h1)
    limp = 1'h0;
    i_csa_host.rd(7'h10, b);
    `CHK(b, 8'h00)
    i_csa_host.wr(CTL, 8'h08);
    `CHK(conv, 1'h0)
    i_csa_host.rd(STS, b);
    `CHK(b, 8'h09)
    reset_dut();
    $display("test busy and exit done");
    finish_test();
  end
endmodule
